// ===== rtl/serial_auto_pkg.sv
package serial_auto_pkg;

  // Register map
  localparam logic [15:0] MODE_OFF      = 16'hff68;
  localparam logic [15:0] CTRL_OFF      = 16'hff69;
  localparam logic [15:0] SHIFT_OFF     = 16'hff6a;
  localparam logic [15:0] GAP_OFF       = 16'hff6b;
  localparam logic [15:0] PTR_OFF       = 16'hff6c;
  localparam logic [15:0] BUF_BASE      = 16'hfac0;
  localparam logic [15:0] BUF_TOP       = 16'hfadf;
  localparam int          BUF_BYTES     = 32;

  // Field positions
  localparam int          MODE_EN_BIT   = 7;
  localparam int          MODE_AUTO_BIT = 3;
  localparam int          ACTIVE_BIT    = 3;
  localparam int          FAULT_BIT     = 4;
  localparam int          GAP_EN_BIT    = 7;
  localparam logic [7:0]  CTRL_RO_MASK  = 8'h18;

  // Reset values
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  GAP_RST       = 8'h00;
  localparam logic [7:0]  MODE_RST      = 8'h00;

  // Gap timing in main clocks and serial clocks
  localparam int          GAP_UNIT_CLK  = 128;
  localparam logic [6:0]  GAP_TAIL_CLK  = 7'h38;
  localparam logic [1:0]  GAP_MIN_SCK   = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_LOAD  = 5'h02,
    ST_SHIFT = 5'h04,
    ST_STORE = 5'h08,
    ST_GAP   = 5'h10
  } seq_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpu_req_s;

  typedef struct packed {
    seq_e                        st;
    logic [7:0]                  ctrl;
    logic [7:0]                  gap;
    logic [7:0]                  mode;
    logic [4:0]                  ptr;
    logic [7:0]                  shift;
    logic [2:0]                  bits;
    logic                        so;
    logic [2:0]                  sck_sync;
    logic                        sck_lvl;
    logic [2:0]                  si_sync;
    logic [7:0]                  pre;
    logic [5:0]                  units;
    logic [6:0]                  tail;
    logic [1:0]                  gap_sck;
    logic [12:0]                 gcnt;
    logic [7:0]                  rdata;
    logic                        done_p;
    logic [BUF_BYTES-1:0][7:0]   ram;
  } core_s;

endpackage : serial_auto_pkg

// ===== rtl/auto_buffered_serial_transfer.sv
`timescale 1ns/10ps
module auto_buffered_serial_transfer
  import serial_auto_pkg::*;
#(
  parameter int GAP_UNIT = GAP_UNIT_CLK
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  // Processor register and buffer port
  input  wire cpu_req_s   cpu_i,
  output logic [7:0]      rd_data_o,
  // Serial link
  input  wire logic       sck_i,
  input  wire logic       ser_in_i,
  output logic            ser_out_o,
  // Status
  output logic            xfer_active_o,
  output logic            byte_done_o
);

  // Gap checker counter is 13 bits: 32 units of at most 128 clocks plus tail
  if (GAP_UNIT < 2 || GAP_UNIT > 128 || BUF_BYTES != 32) begin : g_bad_param
    $error("unsupported gap unit or buffer size");
  end

  // Clock stages start at the idle high level, so no false edge follows reset
  localparam core_s CORE_RST = '{st: ST_IDLE, ctrl: CTRL_RST, gap: GAP_RST, mode: MODE_RST,
                                 sck_sync: 3'h7, sck_lvl: 1'b1, default: '0};
  localparam logic [7:0] PRE_LAST = 8'(GAP_UNIT - 1);

  core_s s_ff;
  core_s nxt_s;
  logic  sck_rise;
  logic  sck_fall;
  logic  in_buf;
  logic  auto_on;
  logic [5:0] unit_goal;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.done_p   = 1'b0;
    nxt_s.sck_sync = {s_ff.sck_sync[1:0], sck_i};
    nxt_s.si_sync  = {s_ff.si_sync[1:0], ser_in_i};
    sck_rise  = (s_ff.sck_sync[1] == s_ff.sck_sync[2]) && s_ff.sck_sync[2] && !s_ff.sck_lvl;
    sck_fall  = (s_ff.sck_sync[1] == s_ff.sck_sync[2]) && !s_ff.sck_sync[2] && s_ff.sck_lvl;
    if (s_ff.sck_sync[1] == s_ff.sck_sync[2]) begin
      nxt_s.sck_lvl = s_ff.sck_sync[2];
    end
    in_buf    = (cpu_i.addr >= BUF_BASE) && (cpu_i.addr <= BUF_TOP);
    auto_on   = s_ff.mode[MODE_EN_BIT] && s_ff.mode[MODE_AUTO_BIT];
    unit_goal = 6'(s_ff.gap[4:0]) + 6'h01;

    // Register reads, registered answer
    if (cpu_i.rd) begin
      if (cpu_i.addr == MODE_OFF) begin
        nxt_s.rdata = s_ff.mode;
      end else if (cpu_i.addr == CTRL_OFF) begin
        nxt_s.rdata = s_ff.ctrl;
      end else if (cpu_i.addr == SHIFT_OFF) begin
        nxt_s.rdata = s_ff.shift;
      end else if (cpu_i.addr == GAP_OFF) begin
        nxt_s.rdata = s_ff.gap;
      end else if (cpu_i.addr == PTR_OFF) begin
        nxt_s.rdata = {3'h0, s_ff.ptr};
      end else if (in_buf) begin
        nxt_s.rdata = s_ff.ram[cpu_i.addr[4:0]];
      end else begin
        nxt_s.rdata = 8'h00;
      end
    end

    // Register writes
    if (cpu_i.wr) begin
      if (cpu_i.addr == MODE_OFF) begin
        nxt_s.mode = cpu_i.wdata;
      end else if (cpu_i.addr == CTRL_OFF) begin
        nxt_s.ctrl = (cpu_i.wdata & ~CTRL_RO_MASK) | (s_ff.ctrl & CTRL_RO_MASK);
      end else if (cpu_i.addr == GAP_OFF) begin
        nxt_s.gap = cpu_i.wdata;
      end else if (cpu_i.addr == PTR_OFF) begin
        nxt_s.ptr = cpu_i.wdata[4:0];
      end else if (cpu_i.addr == SHIFT_OFF && auto_on) begin
        if (s_ff.ctrl[ACTIVE_BIT]) begin
          nxt_s.ctrl[FAULT_BIT] = 1'b1;
        end else begin
          nxt_s.ctrl[ACTIVE_BIT] = 1'b1;
          nxt_s.ctrl[FAULT_BIT]  = 1'b0;
          nxt_s.st               = ST_LOAD;
        end
      end else if (in_buf) begin
        nxt_s.ram[cpu_i.addr[4:0]] = cpu_i.wdata;
      end
    end

    // Automatic sequence
    case (s_ff.st)
      ST_IDLE: begin
        nxt_s.gcnt = 13'h0000;
      end
      ST_LOAD: begin
        nxt_s.shift = s_ff.ram[s_ff.ptr];
        nxt_s.so    = s_ff.ram[s_ff.ptr][7];
        nxt_s.bits  = 3'h0;
        nxt_s.st    = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (sck_rise) begin
          nxt_s.shift = {s_ff.shift[6:0], s_ff.si_sync[2]};
          nxt_s.bits  = s_ff.bits + 3'h1;
          if (s_ff.bits == 3'h7) begin
            nxt_s.st = ST_STORE;
          end
        end else if (sck_fall) begin
          nxt_s.so = s_ff.shift[7];
        end
      end
      ST_STORE: begin
        nxt_s.ram[s_ff.ptr] = s_ff.shift;
        nxt_s.done_p        = 1'b1;
        nxt_s.pre           = 8'h00;
        nxt_s.units         = 6'h00;
        nxt_s.tail          = 7'h00;
        nxt_s.gap_sck       = 2'h0;
        nxt_s.gcnt          = 13'h0000;
        if (s_ff.ptr == 5'h00) begin
          nxt_s.ctrl[ACTIVE_BIT] = 1'b0;
          nxt_s.so               = 1'b0;
          nxt_s.st               = ST_IDLE;
        end else begin
          nxt_s.ptr = s_ff.ptr - 5'h01;
          nxt_s.st  = s_ff.gap[GAP_EN_BIT] ? ST_GAP : ST_LOAD;
        end
      end
      ST_GAP: begin
        // Saturates, so a long wait for serial clocks cannot wrap it
        if (s_ff.gcnt != 13'h1fff) begin
          nxt_s.gcnt = s_ff.gcnt + 13'h0001;
        end
        if (s_ff.units != unit_goal) begin
          nxt_s.pre = (s_ff.pre == PRE_LAST) ? 8'h00 : s_ff.pre + 8'h01;
          if (s_ff.pre == PRE_LAST) begin
            nxt_s.units = s_ff.units + 6'h01;
          end
        end else if (s_ff.tail != GAP_TAIL_CLK) begin
          nxt_s.tail = s_ff.tail + 7'h01;
        end
        if (sck_rise && s_ff.gap_sck != GAP_MIN_SCK) begin
          nxt_s.gap_sck = s_ff.gap_sck + 2'h1;
        end
        if (s_ff.units == unit_goal && s_ff.tail == GAP_TAIL_CLK && s_ff.gap_sck == GAP_MIN_SCK) begin
          nxt_s.st = ST_LOAD;
        end
      end
      default: begin
        nxt_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_ff <= CORE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rd_data_o     = s_ff.rdata;
  assign ser_out_o     = s_ff.so;
  assign xfer_active_o = s_ff.ctrl[ACTIVE_BIT];
  assign byte_done_o   = s_ff.done_p;

  // Checks
  logic [7:0]  load_byte;
  logic [12:0] gap_min;
  assign load_byte = s_ff.ram[s_ff.ptr];
  assign gap_min   = 13'(unit_goal) * 13'(GAP_UNIT) + 13'(GAP_TAIL_CLK);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_last_store;
    s_ff.st == ST_STORE && s_ff.ptr == 5'h00;
  endsequence
  sequence s_gap_exit;
    s_ff.st == ST_GAP && nxt_s.st == ST_LOAD;
  endsequence

  property p_ctrl_ro;
    cpu_i.wr && cpu_i.addr == CTRL_OFF && s_ff.st == ST_IDLE |=> s_ff.ctrl[4:3] == $past(s_ff.ctrl[4:3]);
  endproperty
  a_ctrl_ro: assert property (p_ctrl_ro) else $error("read-only flag changed by write");

  property p_gap_rw;
    cpu_i.wr && cpu_i.addr == GAP_OFF |=> s_ff.gap == $past(cpu_i.wdata);
  endproperty
  a_gap_rw: assert property (p_gap_rw) else $error("gap register not written");

  property p_start;
    cpu_i.wr && cpu_i.addr == SHIFT_OFF && auto_on && !xfer_active_o
      |=> s_ff.st == ST_LOAD && xfer_active_o ##1 s_ff.shift == $past(load_byte);
  endproperty
  a_start: assert property (p_start) else $error("start did not load buffer byte");

  property p_store;
    s_ff.st == ST_STORE && s_ff.ptr != 5'h00 |=> s_ff.ptr == $past(s_ff.ptr) - 5'h01 && byte_done_o;
  endproperty
  a_store: assert property (p_store) else $error("pointer not decremented");

  property p_end;
    s_last_store |=> !xfer_active_o && s_ff.st == ST_IDLE && !ser_out_o;
  endproperty
  a_end: assert property (p_end) else $error("active flag not cleared at end");

  property p_nogap;
    s_ff.st == ST_STORE && s_ff.ptr != 5'h00 && !s_ff.gap[GAP_EN_BIT] |=> s_ff.st == ST_LOAD;
  endproperty
  a_nogap: assert property (p_nogap) else $error("untimed gap inserted");

  property p_gap_len;
    s_gap_exit |-> s_ff.gcnt >= gap_min - 13'h0001 && s_ff.gap_sck == GAP_MIN_SCK;
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("gap ended too early");

  property p_fall_out;
    s_ff.st == ST_SHIFT && sck_fall |=> ser_out_o == $past(s_ff.shift[7]);
  endproperty
  a_fall_out: assert property (p_fall_out) else $error("output bit not updated on falling edge");

  property p_rise_in;
    s_ff.st == ST_SHIFT && sck_rise |=> s_ff.shift[0] == $past(s_ff.si_sync[2]);
  endproperty
  a_rise_in: assert property (p_rise_in) else $error("input bit not sampled on rising edge");

endmodule : auto_buffered_serial_transfer

// ===== verif/serial_peer_model.sv
`timescale 1ns/10ps
module serial_peer_model (
  // Serial link
  output logic      sck_o,
  output logic      sdo_o,
  input  wire logic sdi_i
);
  initial begin
    sck_o = 1'b1;
    sdo_o = 1'b0;
  end

  // Peer clocks one byte MSB first, clock idle high between frames
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    #7;
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      sdo_o = tx[i];
      #80;
      sck_o = 1'b1;
      #40;
      rx[i] = sdi_i;
      if (i > 0) #40;
    end
    sdo_o = ~sdo_o;
  endtask : frame

  // Two clock pulses inside a timed gap
  task automatic pulses();
    repeat (2) begin
      sck_o = 1'b0;
      #80;
      sck_o = 1'b1;
      #80;
    end
  endtask : pulses
endmodule : serial_peer_model

// ===== verif/auto_buffered_serial_transfer_test.sv
`timescale 1ns/10ps
module auto_buffered_serial_transfer_test;
  import serial_auto_pkg::*;
  logic       sys_clk_i;
  logic       srst_i;
  cpu_req_s   cpu_i;
  logic [7:0] rd_data_o;
  logic       sck_i;
  logic       ser_in_i;
  logic       ser_out_o;
  logic       xfer_active_o;
  logic       byte_done_o;
  int         n_fail;
  int         checks_done;
  logic [7:0] rv;
  logic [7:0] rx;

  auto_buffered_serial_transfer #(.GAP_UNIT(4)) dut_u (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .cpu_i(cpu_i), .rd_data_o(rd_data_o),
    .sck_i(sck_i), .ser_in_i(ser_in_i), .ser_out_o(ser_out_o),
    .xfer_active_o(xfer_active_o), .byte_done_o(byte_done_o));

  serial_peer_model peer_u (.sck_o(sck_i), .sdo_o(ser_in_i), .sdi_i(ser_out_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic conclude();
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cpu_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_i); #1;
    cpu_i = '0;
    @(posedge sys_clk_i); #1;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    cpu_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk_i); #1;
    cpu_i = '0;
    @(posedge sys_clk_i); #1;
    d = rd_data_o;
  endtask : rd

  task automatic wait_done();
    int k;
    @(posedge sys_clk_i); #1;
    for (k = 0; k < 400 && byte_done_o !== 1'b1; k++) begin
      @(posedge sys_clk_i); #1;
    end
    chk("byte done", {7'h00, byte_done_o}, 8'h01);
  endtask : wait_done

  task automatic start_run(input logic [7:0] gap);
    wr(GAP_OFF, gap);
    wr(BUF_BASE + 16'h0001, 8'ha4);
    wr(BUF_BASE, 8'h81);
    wr(PTR_OFF, 8'h01);
    wr(MODE_OFF, 8'h88);
    wr(SHIFT_OFF, 8'h00);
  endtask : start_run

  task automatic t_reset();
    rd(CTRL_OFF, rv); chk("ctrl reset", rv, CTRL_RST);
    rd(GAP_OFF, rv); chk("gap reset", rv, GAP_RST);
    rd(MODE_OFF, rv); chk("mode reset", rv, MODE_RST);
  endtask : t_reset

  task automatic t_regs();
    wr(GAP_OFF, 8'h9f);
    rd(GAP_OFF, rv); chk("gap rw", rv, 8'h9f);
    wr(SHIFT_OFF, 8'h5a);
    wr(CTRL_OFF, CTRL_RO_MASK);
    rd(CTRL_OFF, rv); chk("ctrl flags", rv, 8'h00);
    rd(16'hff70, rv); chk("unmapped", rv, 8'h00);
  endtask : t_regs

  task automatic t_run_plain();
    start_run(8'h00);
    rd(CTRL_OFF, rv); chk("active flag", rv, 8'h08);
    wr(SHIFT_OFF, 8'h00);
    rd(CTRL_OFF, rv); chk("fault flag", rv, 8'h18);
    peer_u.frame(8'h5b, rx); chk("first byte", rx, 8'ha4);
    wait_done();
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk("untimed gap", {7'h00, ser_out_o}, 8'h01);
    peer_u.frame(8'hc6, rx); chk("second byte", rx, 8'h81);
    wait_done();
    chk("run end", {7'h00, xfer_active_o}, 8'h00);
    chk("line low", {7'h00, ser_out_o}, 8'h00);
    rd(BUF_BASE + 16'h0001, rv); chk("reply one", rv, 8'h5b);
    rd(BUF_BASE, rv); chk("reply two", rv, 8'hc6);
    rd(PTR_OFF, rv); chk("pointer end", rv, 8'h00);
    rd(SHIFT_OFF, rv); chk("shift last", rv, 8'hc6);
  endtask : t_run_plain

  task automatic t_run_gap();
    start_run(8'h83);
    peer_u.frame(8'h3c, rx); chk("gap first", rx, 8'ha4);
    wait_done();
    peer_u.pulses();
    @(posedge sys_clk_i); #1;
    repeat (43) @(posedge sys_clk_i);
    #1;
    chk("gap held", {7'h00, ser_out_o}, 8'h00);
    repeat (40) @(posedge sys_clk_i);
    #1;
    chk("gap over", {7'h00, ser_out_o}, 8'h01);
    peer_u.frame(8'h99, rx); chk("gap second", rx, 8'h81);
    wait_done();
    chk("gap run end", {7'h00, xfer_active_o}, 8'h00);
  endtask : t_run_gap

  task automatic t_reset_mid();
    start_run(8'h9f);
    chk("mid active", {7'h00, xfer_active_o}, 8'h01);
    @(posedge sys_clk_i); #1;
    srst_i = 1'b1;
    @(posedge sys_clk_i); #1;
    srst_i = 1'b0;
    chk("mid reset active", {7'h00, xfer_active_o}, 8'h00);
    chk("mid reset line", {7'h00, ser_out_o}, 8'h00);
    t_reset();
  endtask : t_reset_mid

  initial begin
    cpu_i = '0;
    srst_i = 1'b1;
    n_fail = 0;
    checks_done = 0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    t_reset();
    t_regs();
    t_run_plain();
    t_run_gap();
    t_reset_mid();
    conclude();
  end

  initial begin
    #100000;
    n_fail++;
    conclude();
  end
endmodule : auto_buffered_serial_transfer_test
